// ### hdl/lppc_pkg.sv
/*
 Constants, field layouts, reset values and types of the low-power pulse
 counter: register map, timing counts, counting modes, calibration states.
 Assumes a single 100 MHz clock that belongs to the always-on timebase.
*/
// Function
// [R1] Two 24-bit counters only increment and wrap from all ones to zero.
// [R2] A counter overflow can raise a processor wake-up event.
// [R3] Two 24-bit comparators wake the processor when a counter hits threshold.
// [R4] Sampling, debounce and pull-up timing come from the always-on clock.
// [R5] Software keeps the always-on clock running while pulses are counted.
// [R6] Counting is enabled only when the mode field selects a counting mode.
// [R7] Every write to the mode register clears both counters.
// [R8] Software writes to the counters are ignored; they are read-only.
// [R9] Single mode counts input A into counter 0; counter 1 stays idle.
// [R10] Dual mode counts input A into counter 0, input B into counter 1.
// [R11] Dual mode shares one pull-up, sample rate and debounce for both.
// [R12] Quadrature: clockwise steps bump counter 0, counter-clockwise counter 1.
// [R13] Clockwise order LL-HL-HH-LH, reverse LL-LH-HH-HL, letters B then A.
// [R14] Counting continues asleep; single input edges never wake the processor.
// [R15] Pull-up strength is programmable; calibration finds the weakest working.
// [R16] Sample interval from 250 us to 2 ms, chosen by mode bits 5:4.
// [R17] During calibration integrators ignore inputs and counters hold.
// [R18] A quadrature transition that skips a state counts nothing.
// [R19] Decoding and counting use debounced states updated once per tick.
package lppc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int SAMPLE_BASE_US = 250;
   localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_US * CLK_MHZ;
   localparam int PU_CHARGE_NS = 2000;
   localparam int PU_CHARGE_CYC = (PU_CHARGE_NS * CLK_MHZ) / 1000;
   localparam int TICK_W = 20;
   localparam logic [7:0] CAL_TEST_TICKS = 8'h03;

   // ==========================================================
   // Widths
   localparam int CNT_W = 24;
   localparam int DEB_W = 4;
   localparam int ADDR_W = 8;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_PULLUP = 8'h04;
   localparam logic [7:0] REG_CNT0 = 8'h08;
   localparam logic [7:0] REG_CNT1 = 8'h0C;
   localparam logic [7:0] REG_THR0 = 8'h10;
   localparam logic [7:0] REG_THR1 = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_WAKE_EN = 8'h1C;
   localparam logic [7:0] REG_DEBOUNCE = 8'h20;

   // ==========================================================
   // Field positions
   localparam int MODE_CM_LSB = 6;
   localparam int MODE_SI_LSB = 4;
   localparam int PU_DUTY_LSB = 0;
   localparam int PU_STR_LSB = 2;
   localparam int PU_CALPORT_BIT = 5;
   localparam int PU_CALGO_BIT = 6;
   localparam int PU_CALBUSY_BIT = 7;
   localparam int PU_CALFAIL_BIT = 8;
   localparam int ST_OVF0 = 0;
   localparam int ST_OVF1 = 1;
   localparam int ST_THR0 = 2;
   localparam int ST_THR1 = 3;

   // ==========================================================
   // Reset values
   localparam logic [1:0] SI_RST = 2'h0;
   localparam logic [2:0] PU_STR_RST = 3'h4;
   localparam logic [1:0] PU_DUTY_RST = 2'h0;
   localparam logic [DEB_W-1:0] DEB_RST = 4'h2;
   localparam logic [CNT_W-1:0] THR_RST = 24'hFFFFFF;
   localparam logic [3:0] WEN_RST = 4'h0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      CM_OFF = 2'h0,
      CM_SINGLE = 2'h1,
      CM_DUAL = 2'h2,
      CM_QUAD = 2'h3
   } lppc_mode_type;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_TEST = 2'b10
   } lppc_cal_type;
endpackage : lppc_pkg

// ### hdl/lppc_smp_if.sv
/*
 Link between the pulse counter core and its input sampler.
 Assumes both ends run on the same clock; no crossing here.
*/
`timescale 1ns/1ps
interface lppc_smp_if;
   import lppc_pkg::*;
   logic tick;
   logic freeze;
   logic [DEB_W-1:0] limit;
   logic [1:0] deb;
   logic upd;
   logic [1:0] level;
   // Core drives timing and debounce depth, sampler returns states
   modport ctrl (output tick, freeze, limit, input deb, upd, level);
   modport smp (input tick, freeze, limit, output deb, upd, level);
endinterface : lppc_smp_if

// ### hdl/lppc_sampler.sv
/*
 Input sampler: synchronises both pulse pins and runs one debounce
 integrator per channel on each sample tick outside calibration.
 Assumes the core supplies a one-cycle tick and a shared depth.
*/
`timescale 1ns/1ps
module lppc_sampler (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pulse pins, asynchronous
   input wire logic pin_a_i,
   input wire logic pin_b_i,
   // Core side
   lppc_smp_if.smp smp
);
   import lppc_pkg::*;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0][DEB_W-1:0] integ;
      logic [1:0] deb;
      logic upd;
   } lppc_smp_state_type;

   lppc_smp_state_type r;
   lppc_smp_state_type next_r;

   // ==========================================================
   // Integrators
   // Both channels share one depth so they behave alike. [R11]
   always_comb begin
      next_r = r;
      next_r.s1 = {pin_b_i, pin_a_i};
      next_r.s2 = r.s1;
      next_r.upd = 1'b0;
      // Frozen during calibration so the charging input is not counted
      if (smp.tick && !smp.freeze) begin // [R17]
         for (int ch = 0; ch < 2; ch++) begin
            if (r.s2[ch] && r.integ[ch] < smp.limit) begin
               next_r.integ[ch] = r.integ[ch] + 1'b1;
            end else if (!r.s2[ch] && r.integ[ch] != '0) begin
               next_r.integ[ch] = r.integ[ch] - 1'b1;
            end
            if (smp.limit == '0) begin
               next_r.deb[ch] = r.s2[ch];
            end else if (next_r.integ[ch] == smp.limit) begin
               next_r.deb[ch] = 1'b1;
            end else if (next_r.integ[ch] == '0) begin
               next_r.deb[ch] = 1'b0;
            end
         end
         next_r.upd = 1'b1; // [R19]
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs toward the core
   assign smp.deb = r.deb;
   assign smp.upd = r.upd;
   assign smp.level = r.s2;
endmodule : lppc_sampler

// ### hdl/lppc_top.sv
/*
 Low-power pulse counter core: Wishbone register slave, sample tick,
 pull-up control with calibration, mode decode, two 24-bit counters,
 threshold comparators and sticky wake-up flags.
 Assumes classic Wishbone on clk_i and asynchronous pulse pins.
*/
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module lppc_top #(
   parameter int SAMPLE_BASE_CYCLES = lppc_pkg::SAMPLE_BASE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [lppc_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Meter sensor pins
   input wire logic pulse_input_a_i,
   input wire logic pulse_input_b_i,
   // Pull-up control
   output logic pullup_en_o,
   output logic [2:0] pullup_sel_o,
   // Wake-up request
   output logic wake_o
);
   import lppc_pkg::*;

   // ==========================================================
   // Elaboration checks
   if (SAMPLE_BASE_CYCLES < 2 ||
       SAMPLE_BASE_CYCLES * 8 >= 2 ** TICK_W) begin : g_bad_base
      $error("SAMPLE_BASE_CYCLES does not fit the tick counter");
   end
   if (PU_CHARGE_CYC * 8 >= SAMPLE_BASE_CYCLES) begin : g_bad_charge
      $error("Pull-up charge window longer than a sample interval");
   end

   // ==========================================================
   // State
   typedef struct packed {
      lppc_mode_type cm;
      logic [1:0] si;
      logic [2:0] pu_str;
      logic [1:0] pu_duty;
      logic cal_port;
      logic cal_fail;
      lppc_cal_type cal;
      logic [2:0] cal_str;
      logic [7:0] cal_ticks;
      logic [DEB_W-1:0] deb_lim;
      logic [CNT_W-1:0] thr0;
      logic [CNT_W-1:0] thr1;
      logic [CNT_W-1:0] cnt0;
      logic [CNT_W-1:0] cnt1;
      logic [1:0] prev;
      logic [3:0] flags;
      logic [3:0] wen;
      logic [TICK_W-1:0] tick_cnt;
      logic tick;
      logic pu_en;
      logic [2:0] pu_sel;
      logic wake;
      logic ack;
      logic [31:0] dat;
   } lppc_top_state_type;

   localparam lppc_top_state_type RST_STATE = '{
      cm: CM_OFF,
      si: SI_RST,
      pu_str: PU_STR_RST,
      pu_duty: PU_DUTY_RST,
      cal: CAL_IDLE,
      deb_lim: DEB_RST,
      thr0: THR_RST,
      thr1: THR_RST,
      wen: WEN_RST,
      default: '0
   };

   lppc_top_state_type r;
   lppc_top_state_type next_r;
   lppc_smp_if smp_link ();

   // ==========================================================
   // Functions
   // Increment with wrap; the top bit flags the all-ones to zero roll
   function automatic logic [CNT_W:0] bump(input logic [CNT_W-1:0] v);
      bump = {1'b0, v} + {{CNT_W{1'b0}}, 1'b1}; // [R1]
   endfunction : bump

   // Quadrature step from {B,A} states: bit 0 clockwise, bit 1 reverse.
   // Anything not one step away, including a skip, returns zero.
   function automatic logic [1:0] quad_step(input logic [1:0] p,
                                            input logic [1:0] c);
      quad_step = 2'h0;
      case (p) // [R13] [R18]
         2'b00: quad_step = {c == 2'b01, c == 2'b10};
         2'b10: quad_step = {c == 2'b00, c == 2'b11};
         2'b11: quad_step = {c == 2'b10, c == 2'b01};
         2'b01: quad_step = {c == 2'b11, c == 2'b00};
         default: quad_step = 2'h0;
      endcase
   endfunction : quad_step

   // Byte-lane merge of a write into an existing word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[8*b +: 8] = wd[8*b +: 8];
         end
      end
   endfunction : merge

   // ==========================================================
   // Sampler
   lppc_sampler u_sampler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_a_i(pulse_input_a_i),
      .pin_b_i(pulse_input_b_i),
      .smp(smp_link.smp)
   );

   // Timing and debounce depth toward the sampler
   assign smp_link.tick = r.tick;
   assign smp_link.freeze = (r.cal == CAL_TEST);
   assign smp_link.limit = r.deb_lim;

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic access;
      logic wr;
      logic [31:0] wd;
      logic [31:0] rd;
      logic [1:0] step;
      logic inc0;
      logic inc1;
      logic [CNT_W:0] b0;
      logic [CNT_W:0] b1;
      logic [3:0] set;
      logic [3:0] clr;
      logic [TICK_W-1:0] charge;
      access = 1'b0;
      wr = 1'b0;
      wd = 32'h0;
      rd = 32'h0;
      step = 2'h0;
      inc0 = 1'b0;
      inc1 = 1'b0;
      b0 = bump(r.cnt0);
      b1 = bump(r.cnt1);
      set = 4'h0;
      clr = 4'h0;
      charge = TICK_W'(PU_CHARGE_CYC << r.pu_duty);
      next_r = r;

      // Sample tick from the timebase; interval doubles per step
      next_r.tick = 1'b0;
      if (r.tick_cnt == '0) begin // [R4] [R16]
         next_r.tick_cnt = TICK_W'((SAMPLE_BASE_CYCLES << r.si) - 1);
         next_r.tick = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt - 1'b1;
      end

      // One pull-up shared by both channels; outside calibration on just before each tick in a counting mode with nonzero strength.
      // Charging only near the sample point saves most of the current.
      if (r.cal == CAL_TEST) begin // [R15]
         next_r.pu_en = 1'b1;
         next_r.pu_sel = r.cal_str;
      end else begin // [R11]
         next_r.pu_en = (r.cm != CM_OFF) && (r.pu_str != 3'h0) &&
                        (r.tick_cnt < charge);
         next_r.pu_sel = r.pu_str;
      end

      // Calibration: raise strength until the open input reads high
      case (r.cal)
         CAL_IDLE: begin
         end
         CAL_TEST: begin
            if (r.tick) begin // [R15]
               if (r.cal_ticks == CAL_TEST_TICKS - 8'h01) begin
                  next_r.cal_ticks = 8'h00;
                  if (smp_link.level[r.cal_port]) begin
                     next_r.pu_str = r.cal_str;
                     next_r.cal = CAL_IDLE;
                  end else if (r.cal_str == 3'h7) begin
                     next_r.cal_fail = 1'b1;
                     next_r.cal = CAL_IDLE;
                  end else begin
                     next_r.cal_str = r.cal_str + 3'h1;
                  end
               end else begin
                  next_r.cal_ticks = r.cal_ticks + 8'h01;
               end
            end
         end
         default: next_r.cal = CAL_IDLE;
      endcase

      // Counting on each debounced update, never while calibrating
      if (smp_link.upd) begin // [R19]
         next_r.prev = smp_link.deb;
         step = quad_step(r.prev, smp_link.deb);
         case (r.cm) // [R6]
            CM_SINGLE: begin // [R9]
               inc0 = !r.prev[0] && smp_link.deb[0];
            end
            CM_DUAL: begin // [R10]
               inc0 = !r.prev[0] && smp_link.deb[0];
               inc1 = !r.prev[1] && smp_link.deb[1];
            end
            CM_QUAD: begin // [R12]
               inc0 = step[0];
               inc1 = step[1];
            end
            default: begin
               inc0 = 1'b0;
               inc1 = 1'b0;
            end
         endcase
      end
      if (inc0) begin // [R1]
         next_r.cnt0 = b0[CNT_W-1:0];
         set[ST_OVF0] = b0[CNT_W]; // [R2]
         set[ST_THR0] = (b0[CNT_W-1:0] == r.thr0); // [R3]
      end
      if (inc1) begin
         next_r.cnt1 = b1[CNT_W-1:0];
         set[ST_OVF1] = b1[CNT_W];
         set[ST_THR1] = (b1[CNT_W-1:0] == r.thr1);
      end

      // Wishbone access; ack stands one cycle, writes act with it
      access = wb_cyc_i && wb_stb_i && !r.ack;
      wr = access && wb_we_i;
      next_r.ack = access;
      case (wb_adr_i)
         REG_MODE: rd = {24'h0, r.cm, r.si, 4'h0};
         REG_PULLUP: rd = {23'h0, r.cal_fail, r.cal == CAL_TEST,
                           1'b0, r.cal_port, r.pu_str, r.pu_duty};
         REG_CNT0: rd = {8'h00, r.cnt0};
         REG_CNT1: rd = {8'h00, r.cnt1};
         REG_THR0: rd = {8'h00, r.thr0};
         REG_THR1: rd = {8'h00, r.thr1};
         REG_STATUS: rd = {28'h0, r.flags};
         REG_WAKE_EN: rd = {28'h0, r.wen};
         REG_DEBOUNCE: rd = {{(32-DEB_W){1'b0}}, r.deb_lim};
         default: rd = 32'h0;
      endcase
      next_r.dat = access ? rd : 32'h0;

      if (wr) begin
         wd = merge(rd, wb_dat_i, wb_sel_i);
         case (wb_adr_i)
            REG_MODE: begin
               next_r.cm = lppc_mode_type'(wd[MODE_CM_LSB +: 2]);
               next_r.si = wd[MODE_SI_LSB +: 2];
               // Clear wins over a same-cycle increment
               next_r.cnt0 = '0; // [R7]
               next_r.cnt1 = '0;
               next_r.prev = smp_link.deb;
            end
            REG_PULLUP: begin
               // Settings frozen while calibration owns the pull-up
               if (r.cal == CAL_IDLE) begin
                  next_r.pu_duty = wd[PU_DUTY_LSB +: 2];
                  next_r.pu_str = wd[PU_STR_LSB +: 3];
                  next_r.cal_port = wd[PU_CALPORT_BIT];
                  if (wd[PU_CALGO_BIT]) begin // [R15]
                     next_r.cal = CAL_TEST;
                     next_r.cal_str = 3'h1;
                     next_r.cal_ticks = 8'h00;
                     next_r.cal_fail = 1'b0;
                  end
               end
            end
            REG_THR0: next_r.thr0 = wd[CNT_W-1:0];
            REG_THR1: next_r.thr1 = wd[CNT_W-1:0];
            REG_STATUS: clr = wd[3:0];
            REG_WAKE_EN: next_r.wen = wd[3:0];
            REG_DEBOUNCE: next_r.deb_lim = wd[DEB_W-1:0];
            // Counters are read-only, writes fall here
            default: clr = 4'h0; // [R8]
         endcase
      end

      // Sticky flags, write one to clear; a new event beats the clear
      next_r.flags = (r.flags & ~clr) | set;
      // Only overflow and threshold events wake, never single edges
      next_r.wake = |(next_r.flags & r.wen); // [R14]
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= RST_STATE;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs, all straight from flops
   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;
   assign pullup_en_o = r.pu_en;
   assign pullup_sel_o = r.pu_sel;
   assign wake_o = r.wake;
endmodule : lppc_top

// ### bench/lppc_chk.sv
/*
 Checker for the pulse counter top: bus handshake, idle outputs and
 wake-up causes, seen only through the top module's ports.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module lppc_chk
   import lppc_pkg::*;
#(
   parameter int SAMPLE_BASE_CYCLES = SAMPLE_BASE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins and outputs
   input wire logic pulse_input_a_i,
   input wire logic pulse_input_b_i,
   input wire logic pullup_en_o,
   input wire logic [2:0] pullup_sel_o,
   input wire logic wake_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Helpers: cycles since a taken write, any wake source enabled
   logic [3:0] since_wr;
   logic en_any;
   wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_wr <= 4'hF;
         en_any <= 1'b0;
      end else begin
         // Saturate so a long idle never wraps back to a small value
         if (taken && wb_we_i) since_wr <= 4'h0;
         else if (since_wr != 4'hF) since_wr <= since_wr + 4'h1;
         if (taken && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_WAKE_EN)
            en_any <= (wb_dat_i[3:0] != 4'h0);
      end
   end
   // ==========================================================
   // Properties
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK_NEXT: assert property (s_req |=> s_ans)
      else $error("request not answered in one cycle");
   AST_ACK_CAUSE: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RST_QUIET: assert property ($fell(rst_i) |->
      !wake_o && !pullup_en_o && !wb_ack_o && pullup_sel_o == 3'h0)
      else $error("outputs active after reset");
   AST_PU_STR: assert property (
      pullup_en_o |-> pullup_sel_o != 3'h0)
      else $error("pull-up on with zero strength");
   // Wake is registered from the old enables, so allow one cycle of lag
   AST_WAKE_GATE: assert property (
      !en_any && !$past(en_any) |-> !wake_o)
      else $error("wake with all sources disabled");
   AST_WAKE_FALL: assert property (
      $fell(wake_o) |-> since_wr < 4'h8)
      else $error("wake dropped without a write");
   AST_ACK_BUSY: assert property (wb_ack_o |-> !$past(wb_ack_o))
      else $error("ack longer than one cycle");
endmodule : lppc_chk

bind lppc_top lppc_chk #(.SAMPLE_BASE_CYCLES(SAMPLE_BASE_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pulse_input_a_i(pulse_input_a_i), .pulse_input_b_i(pulse_input_b_i),
   .pullup_en_o(pullup_en_o), .pullup_sel_o(pullup_sel_o),
   .wake_o(wake_o));

// ### bench/lppc_sensor_model.sv
/*
 Change-over reed switch pair standing in for a meter encoder.
 Assumes the bench holds each state longer than one sample period.
*/
`timescale 1ns/1ps
module lppc_sensor_model (
   // Clock
   input wire logic clk_i,
   // Switch contacts
   output logic pin_a_o,
   output logic pin_b_o
);
   // ==========================================================
   // Both contacts driven, so no pull-up is needed and none floats
   initial begin
      pin_a_o = 1'b0;
      pin_b_o = 1'b0;
   end
   // Move to state {b, a} just after an edge and dwell there
   task automatic step(input logic [1:0] ba, input int hold);
      @(posedge clk_i);
      pin_b_o <= ba[1];
      pin_a_o <= ba[0];
      repeat (hold) @(posedge clk_i);
   endtask : step
endmodule : lppc_sensor_model

// ### bench/lppc_tb_top.sv
/*
 Self-checking bench for the pulse counter: registers, modes, threshold
 wake-up. Assumes a shortened sample period set by parameter.
*/
`timescale 1ns/1ps
module lppc_tb_top;
   import lppc_pkg::*;
   // ==========================================================
   // Set-up
   localparam int BASE = 2000;
   localparam int HOLD = BASE + 10; // One tick per state, plus sync slack
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic pin_a;
   logic pin_b;
   logic pullup_en_o;
   logic [2:0] pullup_sel_o;
   logic wake_o;
   logic [31:0] rd;
   int err_total = 0;
   int n_compared = 0;
   // Clock never stops while pulses are counted
   always #5 clk_i = ~clk_i;
   lppc_sensor_model sensor (.clk_i(clk_i), .pin_a_o(pin_a),
      .pin_b_o(pin_b));
   lppc_top #(.SAMPLE_BASE_CYCLES(BASE)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pulse_input_a_i(pin_a),
      .pulse_input_b_i(pin_b), .pullup_en_o(pullup_en_o),
      .pullup_sel_o(pullup_sel_o), .wake_o(wake_o));
   // ==========================================================
   // Shared tasks
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One classic cycle; held until ack is sampled, bounded wait
   task automatic wb(input logic we, input logic [7:0] adr,
         input logic [31:0] wd, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         $display("BAD bus timeout at %h", adr);
         print_verdict();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      wb(1'b1, adr, d, rd);
   endtask : wr
   task automatic rc(input string nm, input logic [7:0] adr,
         input logic [31:0] exp);
      wb(1'b0, adr, 32'h0, rd);
      chk(nm, rd, exp);
   endtask : rc
   task automatic st(input logic [1:0] ba);
      sensor.step(ba, HOLD);
   endtask : st
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rc("mode", REG_MODE, 32'h0);
      rc("thr0", REG_THR0, 32'h00FFFFFF);
      rc("cnt1", REG_CNT1, 32'h0);
      rc("pullup", REG_PULLUP, 32'h10);
      rc("debounce", REG_DEBOUNCE, 32'h2);
      rc("unmapped", 8'h40, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_single();
      wr(REG_DEBOUNCE, 32'h0);
      wr(REG_MODE, 32'h40);
      st(2'b01); st(2'b00); st(2'b01); st(2'b00);
      st(2'b10); st(2'b00); // Input B must not count here
      rc("single cnt0", REG_CNT0, 32'h2);
      rc("single cnt1", REG_CNT1, 32'h0);
      wr(REG_CNT0, 32'h123);
      rc("cnt0 after write", REG_CNT0, 32'h2);
      chk("wake idle", {31'h0, wake_o}, 32'h0);
      $display("test single done");
   endtask : t_single
   task automatic t_dual();
      wr(REG_MODE, 32'h80);
      rc("cleared cnt0", REG_CNT0, 32'h0);
      st(2'b11); st(2'b00); st(2'b10); st(2'b00);
      rc("dual cnt0", REG_CNT0, 32'h1);
      rc("dual cnt1", REG_CNT1, 32'h2);
      $display("test dual done");
   endtask : t_dual
   task automatic t_quad();
      wr(REG_MODE, 32'hC0);
      rc("cleared cnt1", REG_CNT1, 32'h0);
      st(2'b10); st(2'b11); st(2'b01); st(2'b00); // Clockwise
      st(2'b01); st(2'b11); st(2'b10); st(2'b00); // Counter-clockwise
      st(2'b11); st(2'b00); // Skipped states count nothing
      rc("quad cnt0", REG_CNT0, 32'h4);
      rc("quad cnt1", REG_CNT1, 32'h4);
      rc("quad skip", REG_CNT0, 32'h4);
      $display("test quad done");
   endtask : t_quad
   task automatic t_thr();
      wr(REG_MODE, 32'h0);
      st(2'b01); st(2'b00);
      rc("off cnt0", REG_CNT0, 32'h0);
      wr(REG_THR0, 32'h2);
      wr(REG_WAKE_EN, 32'h4);
      wr(REG_MODE, 32'h40);
      st(2'b01); st(2'b00);
      chk("wake below thr", {31'h0, wake_o}, 32'h0);
      st(2'b01); st(2'b00);
      chk("wake at thr", {31'h0, wake_o}, 32'h1);
      rc("status", REG_STATUS, 32'h4);
      wr(REG_STATUS, 32'h4);
      repeat (3) @(posedge clk_i);
      chk("wake cleared", {31'h0, wake_o}, 32'h0);
      $display("test threshold done");
   endtask : t_thr
   // Calibration with input A driven high by the sensor model settles at the weakest strength
   task automatic t_cal();
      st(2'b01);
      wr(REG_PULLUP, 32'h40);
      rc("cal busy", REG_PULLUP, 32'h80);
      chk("cal pu on", {31'h0, pullup_en_o}, 32'h1);
      chk("cal pu sel", {29'h0, pullup_sel_o}, 32'h1);
      repeat (4 * BASE) @(posedge clk_i);
      rc("cal result", REG_PULLUP, 32'h04);
      chk("pu sel after", {29'h0, pullup_sel_o}, 32'h1);
      $display("test calibration done");
   endtask : t_cal
   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_single();
      t_dual();
      t_quad();
      t_thr();
      t_cal();
      print_verdict();
   end
endmodule : lppc_tb_top
